// ==== shared/bcd_pkg.sv ====
// Package: constants for the three-digit BCD up/down counter
package bcd_pkg;

  // ---------------------------------------------------------------
  // Digit layout
  // ---------------------------------------------------------------
  localparam int          DIGITS     = 3;
  localparam int          DIGIT_W    = 4;
  localparam int          COUNT_W    = DIGITS * DIGIT_W;
  localparam logic [3:0]  DIGIT_MAX  = 4'h9;
  localparam logic [3:0]  DIGIT_MIN  = 4'h0;
  localparam logic [11:0] COUNT_MAX  = 12'h0999;
  localparam logic [11:0] COUNT_MIN  = 12'h0000;
  localparam logic [11:0] COUNT_RST  = 12'h0000;

  // ---------------------------------------------------------------
  // AXI4-Lite register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W     = 4;
  localparam logic [3:0]  REG_COUNT  = 4'h0;  // RO current count
  localparam logic [3:0]  REG_STATUS = 4'h4;  // RO status bits
  localparam int          ST_TERM    = 0;
  localparam int          ST_CARRY   = 1;
  localparam int          ST_DIR     = 2;
  localparam int          ST_ENABLE  = 3;
  localparam int          ST_LOAD_N  = 4;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

endpackage : bcd_pkg

// ==== hdl/bcd_updown_counter.sv ====
// Module: three-digit BCD up/down counter with AXI4-Lite status view
//
// Functional notes
// R01: Count changes only on count pulse rise
// R02: Enable high counts, low holds value
// R03: Active-low load forces data, top priority
// R04: After load release, data inputs ignored
// R05: Direction low counts up, high down
// R06: Direction changes only while pulse high
// R07: Carry follows pulse at terminal value
// R08: Terminal flag high at 999 up/000 down
// R09: Carry drives next stage; controls paralleled
// R10: Three BCD digits, synchronous either direction
// R11: Direction change leaves count unchanged
// R12: Digits wrap with carry or borrow
// R13: Pulse synchronised, one step per rise
`timescale 1ns/1ps

module bcd_updown_counter
  import bcd_pkg::*;
(
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Counter pins (asynchronous to aclk)
  input  wire logic               count_in,
  input  wire logic               enable,
  input  wire logic               load_n,
  input  wire logic               down,
  input  wire logic [COUNT_W-1:0] data_in,
  // Counter outputs
  output logic      [COUNT_W-1:0] count_out,
  output logic                    carry_out,
  output logic                    term_state,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]         s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0]        s_axi_rdata,
  output logic      [1:0]         s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic               cnt_s1, cnt_s2, cnt_d;
  logic               en_s1, en_s2;
  logic               ld_s1, ld_s2;
  logic               dn_s1, dn_s2;
  logic [COUNT_W-1:0] dat_s1, dat_s2;
  logic [COUNT_W-1:0] count;
  logic               term;
  logic               count_rise;

  // R13: two-stage sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_s1 <= 1'b0;
      cnt_s2 <= 1'b0;
      cnt_d  <= 1'b0;
      en_s1  <= 1'b0;
      en_s2  <= 1'b0;
      ld_s1  <= 1'b1;
      ld_s2  <= 1'b1;
      dn_s1  <= 1'b0;
      dn_s2  <= 1'b0;
      dat_s1 <= COUNT_RST;
      dat_s2 <= COUNT_RST;
    end else begin
      cnt_s1 <= count_in;
      cnt_s2 <= cnt_s1;
      cnt_d  <= cnt_s2;
      en_s1  <= enable;
      en_s2  <= en_s1;
      ld_s1  <= load_n;
      ld_s2  <= ld_s1;
      dn_s1  <= down;
      dn_s2  <= dn_s1;
      dat_s1 <= data_in;
      dat_s2 <= dat_s1;
    end
  end

  // R13: one step per rise
  assign count_rise = cnt_s2 & ~cnt_d;

  // ---------------------------------------------------------------
  // BCD step function
  // ---------------------------------------------------------------
  // R12: digit wrap with carry
  function automatic logic [COUNT_W-1:0] bcd_step(
    input logic [COUNT_W-1:0] val,
    input logic               dn
  );
    logic [COUNT_W-1:0] res;
    logic               ripple;
    logic [3:0]         dig;
    res    = val;
    ripple = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      dig = val[i*DIGIT_W +: DIGIT_W];
      if (ripple) begin
        if (!dn) begin
          ripple = (dig == DIGIT_MAX);
          dig    = ripple ? DIGIT_MIN : dig + 4'h1;
        end else begin
          ripple = (dig == DIGIT_MIN);
          dig    = ripple ? DIGIT_MAX : dig - 4'h1;
        end
      end
      res[i*DIGIT_W +: DIGIT_W] = dig;
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Count register
  // ---------------------------------------------------------------
  // R03: load wins; R04 latch
  // R01: step on rise; R02 enable gate
  // R05: direction; R10 R11 synchronous
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= COUNT_RST;
    end else if (!ld_s2) begin
      count <= dat_s2;
    end else if (count_rise && en_s2) begin
      count <= bcd_step(count, dn_s2);
    end
  end

  // R08: terminal for direction
  assign term = dn_s2 ? (count == COUNT_MIN) : (count == COUNT_MAX);

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  // R07: carry follows pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_out  <= COUNT_RST;
      carry_out  <= 1'b0;
      term_state <= 1'b0;
    end else begin
      count_out  <= count;
      carry_out  <= term & cnt_s2;
      term_state <= term;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write path: no writable registers, answer SLVERR
  // ---------------------------------------------------------------
  logic aw_got, w_got;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !aw_got && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        aw_got        <= 1'b1;
      end
      if (s_axi_wvalid && !w_got && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
        w_got        <= 1'b1;
      end
      if (aw_got && w_got && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_SLVERR;  // Read-only map
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= RESP_OKAY;
        unique case (s_axi_araddr)
          REG_COUNT: s_axi_rdata[COUNT_W-1:0] <= count;
          REG_STATUS: begin
            s_axi_rdata[ST_TERM]   <= term;
            s_axi_rdata[ST_CARRY]  <= term & cnt_s2;
            s_axi_rdata[ST_DIR]    <= dn_s2;
            s_axi_rdata[ST_ENABLE] <= en_s2;
            s_axi_rdata[ST_LOAD_N] <= ld_s2;
          end
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  logic unused_w;
  assign unused_w = ^{s_axi_wdata, s_axi_wstrb, s_axi_awaddr};

endmodule // bcd_updown_counter

// ==== testbench/bcd_updown_counter_chk.sv ====
// Checker: port-level properties of the BCD counter
`timescale 1ns/1ps
module bcd_updown_counter_chk
  import bcd_pkg::*;
(
  // Clock, reset and pins
  input wire logic               aclk, aresetn, count_in, load_n, down,
  input wire logic               enable, carry_out, term_state,
  input wire logic [COUNT_W-1:0] data_in, count_out,
  // Read address and answer
  input wire logic               s_axi_arvalid, s_axi_rvalid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  step_only_a: assert property ($changed(count_out) |->
    $past(count_in, 4) && !$past(count_in, 5) || !$past(load_n, 4))
    else $error("count moved without pulse or load");
  bcd_digits_a: assert property (count_out[3:0] <= 4'h9 &&
    count_out[7:4] <= 4'h9 && count_out[11:8] <= 4'h9)
    else $error("digit out of range");
  term_flag_a: assert property ($stable(down)[*6] |->
    term_state == (count_out == (down ? COUNT_MIN : COUNT_MAX)))
    else $error("terminal flag wrong");
  carry_follow_a: assert property (carry_out |-> $past(count_in, 3))
    else $error("carry without pulse");
  carry_term_a: assert property (term_state && $past(term_state) &&
    $past(count_in, 3) |-> carry_out)
    else $error("carry missing at terminal");
  load_track_a: assert property ((!load_n && $stable(data_in))[*6]
    |-> count_out == data_in)
    else $error("load did not force data");
  enable_hold_a: assert property ((!enable)[*8] |->
    $stable(count_out) || !$past(load_n, 4))
    else $error("count moved while disabled");
  read_answer_a: assert property ($rose(s_axi_arvalid) |=> s_axi_rvalid)
    else $error("read answer late");
  cover property (carry_out);
  cover property (term_state && down);
  cover property (!load_n ##1 load_n);
endmodule // bcd_updown_counter_chk

bind bcd_updown_counter bcd_updown_counter_chk i_chk (.aclk(aclk),
  .aresetn(aresetn), .count_in(count_in), .load_n(load_n), .down(down),
  .enable(enable), .carry_out(carry_out), .term_state(term_state),
  .data_in(data_in), .count_out(count_out),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid));

// ==== testbench/bcd_ctl_model.sv ====
// Model: external control logic driving the count pins
`timescale 1ns/1ps
module bcd_ctl_model (
  // Clock and bench requests
  input wire logic aclk,
  input wire logic go,
  input wire logic dir_req,
  // Counter pins
  output logic     count_in,
  output logic     down
);
  logic [3:0] ph = 4'h0;
  initial count_in = 1'b0;
  initial down = 1'b0;
  // One pulse per request: six cycles high, six low
  always @(posedge aclk) begin
    if (ph != 4'h0 || go) ph <= (ph == 4'hc) ? 4'h0 : ph + 4'h1;
    count_in <= ph >= 4'h1 && ph <= 4'h6;
  end
  always @(posedge aclk) if (count_in) down <= dir_req;
endmodule // bcd_ctl_model

// ==== testbench/bcd_updown_counter_tb.sv ====
// Testbench: BCD counter pins and status bus
`timescale 1ns/1ps
module bcd_updown_counter_tb
  import bcd_pkg::*;
;
  logic aclk = 1'b0, aresetn, enable, load_n, go, dir_req;
  logic count_in, down, carry_out, term_state;
  logic [11:0] data_in, count_out;
  logic awv, wv, bv, br, awr, wr_, arv, arr, rv, rr;
  logic [3:0] awa, ara;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d, wdata = 32'h0000_0999;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] r;
  int fail_count = 0, num_checks = 0, carries = 0;
  logic carry_q = 1'b0;
  always #2.5 aclk = ~aclk;
  // next stage model: counts carry rises
  always @(posedge aclk) begin
    if (carry_out === 1'b1 && !carry_q) carries++;
    carry_q <= (carry_out === 1'b1);
  end
  bcd_ctl_model i_ctl (.aclk(aclk), .go(go), .dir_req(dir_req),
    .count_in(count_in), .down(down));
  bcd_updown_counter i_dut (.aclk(aclk), .aresetn(aresetn),
    .count_in(count_in), .enable(enable), .load_n(load_n), .down(down),
    .data_in(data_in), .count_out(count_out), .carry_out(carry_out),
    .term_state(term_state), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic cnt(input logic [11:0] e, input logic t);
    check({20'h0_0000, count_out}, {20'h0_0000, e});
    check({31'h0, term_state}, {31'h0, t});
  endtask
  task automatic ld(input logic [11:0] v);
    data_in <= v;
    load_n <= 1'b0;
    wt(8);
    load_n <= 1'b1;
    wt(8);
  endtask
  task automatic pulse();
    go <= 1'b1;
    wt(1);
    go <= 1'b0;
    wt(20);
  endtask
  // Bus cycle: hold each channel until taken, wait for answer
  task automatic axi(input logic w, input logic [3:0] a);
    int n;
    logic rs;
    n = 0;
    rs = 1'b0;
    if (w) begin awa <= a; awv <= 1'b1; wv <= 1'b1; br <= 1'b1; end
    else begin ara <= a; arv <= 1'b1; rr <= 1'b1; end
    // Sample at the rising edge, release what was taken there
    while (!rs && n < 50) begin
      @(posedge aclk);
      n++;
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
      if (arr) arv <= 1'b0;
      rs = w ? bv : rv;
      d = rdata;
      r = w ? bresp : rresp;
    end
    br <= 1'b0;
    rr <= 1'b0;
    // Gap edge so the next call never reassigns a released signal
    @(posedge aclk);
    if (!rs) begin fail_count++; test_done(); end
  endtask
  initial begin
    {aresetn, go, dir_req, awv, wv, br, arv, rr} = 8'h00;
    {enable, load_n, awa, ara, data_in} = {2'b11, 20'h0_0000};
    wt(5);
    aresetn <= 1'b1;
    ld(12'h0998);
    data_in <= 12'h0123;
    wt(8);
    cnt(12'h0998, 1'b0);
    pulse();
    cnt(12'h0999, 1'b1);
    pulse();
    cnt(12'h0000, 1'b0);
    check(carries, 32'h0000_0002);
    enable <= 1'b0;
    dir_req <= 1'b1;
    pulse();
    cnt(12'h0000, 1'b1);
    enable <= 1'b1;
    pulse();
    cnt(12'h0999, 1'b0);
    check(carries, 32'h0000_0004);
    ld(12'h0100);
    pulse();
    cnt(12'h0099, 1'b0);
    axi(1'b0, REG_COUNT);
    check(d, 32'h0000_0099);
    axi(1'b0, REG_STATUS);
    check(d, 32'h0000_001c);
    axi(1'b0, 4'h8);
    check({d[31:2], r}, {30'h0, RESP_SLVERR});
    check(d, 32'h0000_0000);
    axi(1'b1, REG_COUNT);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    cnt(12'h0099, 1'b0);
    // Load held low: pulses ignored, data tracked
    data_in <= 12'h0456;
    load_n <= 1'b0;
    pulse();
    cnt(12'h0456, 1'b0);
    data_in <= 12'h0789;
    wt(8);
    cnt(12'h0789, 1'b0);
    load_n <= 1'b1;
    wt(8);
    test_done();
  end
endmodule // bcd_updown_counter_tb
